//--- hw/mem_out_map.svh
// Default sizes, reset value and latency figures for the memory output stage
`ifndef MEM_OUT_MAP_SVH
`define MEM_OUT_MAP_SVH

// ****************************************************************
// Geometry
// ****************************************************************
`define MEM_DATA_W 16
`define MEM_ADDR_W 10
`define MEM_DEPTH 1024

// ****************************************************************
// Output values and latency
// ****************************************************************
`define OUT_RESET_VAL 16'hffff
`define LATCH_LATENCY 1
`define PRIM_REG_LATENCY 1
`define PORT_COUNT 2

`endif

//--- hw/mem_out_pkg.sv
// Types shared by the memory output stage and its primitive register
package mem_out_pkg;

	// ****************************************************************
	// Reset priority of the primitive output register
	// ****************************************************************
	typedef enum logic [0:0] {
		ce_first_priority    = 1'b0,
		reset_first_priority = 1'b1
	} reset_prio_type;

	// ****************************************************************
	// Per-port control strobes from user logic
	// ****************************************************************
	typedef struct packed {
		logic en;
		logic regce;
		logic srst;
		logic we;
	} port_ctrl_type;

	// ****************************************************************
	// Per-port build options
	// ****************************************************************
	typedef struct packed {
		logic           use_rst;
		logic           prim_reg;
		logic           latch_rst;
		logic           use_regce;
		reset_prio_type prio;
	} port_cfg_type;

endpackage

//--- hw/prim_out_reg.sv
// Primitive output register with selectable reset priority
`timescale 1ns/10ps
`default_nettype none

module prim_out_reg
	import mem_out_pkg::*;
#(
	parameter int             W         = 17,
	parameter logic [W-1:0]   RESET_VAL = '0,
	parameter reset_prio_type PRIO      = ce_first_priority
) (
	input  wire logic         sys_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	input  wire logic         ce,
	input  wire logic         srst,
	output var  logic [W-1:0] q
);

	// ****************************************************************
	// Register
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			q <= RESET_VAL;
		end else if (PRIO == reset_first_priority) begin
			if (srst) begin
				q <= RESET_VAL;
			end else if (ce) begin
				q <= d;
			end
		end else if (ce) begin
			q <= srst ? RESET_VAL : d;
		end
	end

endmodule

`default_nettype wire

//--- hw/memory_output_stage_reset_control.sv
// Two-port block memory with latch and primitive output register reset control
`timescale 1ns/10ps
`default_nettype none

`include "mem_out_map.svh"

// What this block does
// - Register enable acts only on the last stage of the read path; with latch reset, port reset also reaches the latch.
// - Reset priority is selectable only for the output register, never for the latch.
// - With enable priority the register resets only while its enable is high.
// - With reset priority the register resets whatever its enable.
// - Latch reset is offered only with the primitive register present.
// - With latch reset, a one-cycle reset with both stages enabled gives two reset cycles.
// - Without latch reset, only the register resets and gives one reset cycle.
// - Low enables or a long reset may stretch the reset value at the output.
// - Latch and register each have their own reset term.
// - Latch reset needs read enable; register reset needs register enable only with enable priority.
// - With enable priority and no latch reset, reset with only read enable does not reach the output; with only register enable it lasts one cycle.
// - The primitive register adds one cycle of read latency.
// - An option decides whether the port has a reset input at all.
// - Port B has the same reset behaviour as port A, configured separately.
// - Reset with register enable drives the configured reset value to the output.
// - Without a dedicated register enable the register follows read enable.
module memory_output_stage_reset_control
	import mem_out_pkg::*;
#(
	parameter int                  DATA_W        = `MEM_DATA_W,
	parameter int                  ADDR_W        = `MEM_ADDR_W,
	parameter int                  DEPTH         = `MEM_DEPTH,
	parameter logic [DATA_W-1:0]   A_RESET_VAL   = `OUT_RESET_VAL,
	parameter logic                A_USE_RST     = 1'b1,
	parameter logic                A_PRIM_REG    = 1'b1,
	parameter logic                A_LATCH_RST   = 1'b0,
	parameter logic                A_USE_REGCE   = 1'b1,
	parameter reset_prio_type      A_PRIO        = ce_first_priority,
	parameter logic [DATA_W-1:0]   B_RESET_VAL   = `OUT_RESET_VAL,
	parameter logic                B_USE_RST     = 1'b1,
	parameter logic                B_PRIM_REG    = 1'b1,
	parameter logic                B_LATCH_RST   = 1'b0,
	parameter logic                B_USE_REGCE   = 1'b1,
	parameter reset_prio_type      B_PRIO        = ce_first_priority
) (
	input  wire logic              sys_clk,
	input  wire logic              rst,
	input  wire logic              a_en,
	input  wire logic              a_regce,
	input  wire logic              a_rst,
	input  wire logic              a_we,
	input  wire logic [ADDR_W-1:0] a_addr,
	input  wire logic [DATA_W-1:0] a_wdata,
	output var  logic [DATA_W-1:0] a_dout,
	output var  logic              a_dout_valid,
	input  wire logic              b_en,
	input  wire logic              b_regce,
	input  wire logic              b_rst,
	input  wire logic              b_we,
	input  wire logic [ADDR_W-1:0] b_addr,
	input  wire logic [DATA_W-1:0] b_wdata,
	output var  logic [DATA_W-1:0] b_dout,
	output var  logic              b_dout_valid
);

	// ****************************************************************
	// Configuration tables
	// ****************************************************************
	localparam int NP = `PORT_COUNT;

	localparam port_cfg_type CFG [NP] = '{
		'{A_USE_RST, A_PRIM_REG, A_LATCH_RST, A_USE_REGCE, A_PRIO},
		'{B_USE_RST, B_PRIM_REG, B_LATCH_RST, B_USE_REGCE, B_PRIO}
	};

	localparam logic [DATA_W-1:0] RV [NP] = '{A_RESET_VAL, B_RESET_VAL};

	// Read latency in cycles from a taken read enable to data at the port
	localparam int A_LATENCY = `LATCH_LATENCY + (A_PRIM_REG ? `PRIM_REG_LATENCY : 0);
	localparam int B_LATENCY = `LATCH_LATENCY + (B_PRIM_REG ? `PRIM_REG_LATENCY : 0);

	// ****************************************************************
	// Elaboration checks
	// ****************************************************************
	if (DATA_W < 1 || ADDR_W < 1) begin : g_bad_width
		$error("data and address widths must be at least one bit");
	end
	if (DEPTH < 2 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
		$error("depth must fit the address width");
	end
	if (A_LATENCY < 1 || B_LATENCY < 1) begin : g_bad_latency
		$error("read latency cannot be below one cycle");
	end

	// ****************************************************************
	// Port gathering
	// ****************************************************************
	port_ctrl_type     ctrl  [NP];
	logic [ADDR_W-1:0] addr  [NP];
	logic [DATA_W-1:0] wdata [NP];
	logic [DATA_W-1:0] dout  [NP];
	logic              dvld  [NP];

	assign ctrl[0]  = '{a_en, a_regce, a_rst, a_we};
	assign ctrl[1]  = '{b_en, b_regce, b_rst, b_we};
	assign addr[0]  = a_addr;
	assign addr[1]  = b_addr;
	assign wdata[0] = a_wdata;
	assign wdata[1] = b_wdata;

	// ****************************************************************
	// Storage
	// ****************************************************************
	logic [DATA_W-1:0] mem_q [DEPTH];

	// Port B writes last, so it wins a same-address write collision
	always_ff @(posedge sys_clk) begin
		for (int p = 0; p < NP; p++) begin
			if (ctrl[p].en && ctrl[p].we) begin
				mem_q[addr[p]] <= wdata[p];
			end
		end
	end

	// ****************************************************************
	// Per-port read path, identical for both ports
	// ****************************************************************
	for (genvar p = 0; p < NP; p++) begin : g_port
		logic [DATA_W-1:0] latch_q;
		logic              latch_vld_q;
		logic              latch_srst;
		logic              reg_srst;
		logic              reg_ce;

		if (CFG[p].latch_rst && !CFG[p].prim_reg) begin : g_bad_latch_rst
			$error("latch reset needs the primitive output register");
		end
		if (CFG[p].prio == reset_first_priority && !CFG[p].prim_reg) begin : g_bad_prio
			$error("reset priority cannot apply to the memory latch");
		end

		// Latch takes a reset only when it is the last stage or latch reset is chosen
		assign latch_srst = CFG[p].use_rst && ctrl[p].srst
			&& (!CFG[p].prim_reg || CFG[p].latch_rst);

		// Register reset is a term of its own, apart from the latch reset
		assign reg_srst = CFG[p].use_rst && ctrl[p].srst;

		// Dedicated register enable, otherwise the read enable
		assign reg_ce = CFG[p].use_regce ? ctrl[p].regce : ctrl[p].en;

		// ************************************************************
		// Memory latch: enable always outranks reset here
		// ************************************************************
		always_ff @(posedge sys_clk) begin
			if (rst) begin
				latch_q <= RV[p];
			end else if (ctrl[p].en) begin
				latch_q <= latch_srst ? RV[p] : mem_q[addr[p]];
			end
		end

		always_ff @(posedge sys_clk) begin
			if (rst) begin
				latch_vld_q <= 1'b0;
			end else if (ctrl[p].en) begin
				latch_vld_q <= !latch_srst && !ctrl[p].we;
			end
		end

		// ************************************************************
		// Last stage
		// ************************************************************
		if (CFG[p].prim_reg) begin : g_reg
			logic [DATA_W:0] reg_q;

			// Reset value reaches the port only through this register
			prim_out_reg #(
				.W         (DATA_W + 1),
				.RESET_VAL ({1'b0, RV[p]}),
				.PRIO      (CFG[p].prio)
			) u_prim_out_reg (
				.sys_clk (sys_clk),
				.rst     (rst),
				.d       ({latch_vld_q, latch_q}),
				.ce      (reg_ce),
				.srst    (reg_srst),
				.q       (reg_q)
			);

			assign dout[p] = reg_q[DATA_W-1:0];
			assign dvld[p] = reg_q[DATA_W];
		end else begin : g_latch
			assign dout[p] = latch_q;
			assign dvld[p] = latch_vld_q;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign a_dout       = dout[0];
	assign a_dout_valid = dvld[0];
	assign b_dout       = dout[1];
	assign b_dout_valid = dvld[1];

endmodule

`default_nettype wire

//--- tb/mem_out_sva.sv
// Port assertions for the memory output stage
`timescale 1ns/10ps
`default_nettype none
module mem_out_sva
	import mem_out_pkg::*;
#(
	parameter int			DATA_W		= 16,
	parameter logic [DATA_W-1:0]	A_RESET_VAL	= '1,
	parameter logic [DATA_W-1:0]	B_RESET_VAL	= '1
) (
	input wire logic		sys_clk,
	input wire logic		rst,
	input wire logic		a_en,
	input wire logic		a_regce,
	input wire logic		a_rst,
	input wire logic		a_we,
	input wire logic [DATA_W-1:0]	a_dout,
	input wire logic		a_dout_valid,
	input wire logic		b_en,
	input wire logic		b_regce,
	input wire logic		b_rst,
	input wire logic [DATA_W-1:0]	b_dout
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence a_read_s; a_en && !a_we && !a_rst ##1 a_regce && !a_rst; endsequence
	sequence a_reset_s; a_rst && a_en && !a_we ##1 a_regce && !a_rst; endsequence
	sequence b_both_s; b_rst && b_en && b_regce; endsequence
	sequence b_latch_s; b_rst && b_en && !b_regce ##1 b_regce && !b_rst; endsequence
	a_prio_a: assert property (a_rst |=> a_dout == A_RESET_VAL && !a_dout_valid)
		else $error("a reset lost");
	a_hold_a: assert property (!a_regce && !a_rst |=> $stable(a_dout))
		else $error("a moved");
	a_read_lat_a: assert property (a_read_s |=> a_dout_valid)
		else $error("a late");
	a_latch_kept_a: assert property (a_reset_s |=> a_dout_valid)
		else $error("a latch reset");
	b_ce_gate_a: assert property (!b_regce |=> $stable(b_dout))
		else $error("b moved");
	b_reset_val_a: assert property (b_both_s |=> b_dout == B_RESET_VAL)
		else $error("b reset lost");
	b_two_cycle_a: assert property (b_both_s ##1 b_regce |=> b_dout == B_RESET_VAL)
		else $error("b short");
	b_latch_only_a: assert property (b_latch_s |=> b_dout == B_RESET_VAL)
		else $error("b latch");
endmodule
bind memory_output_stage_reset_control mem_out_sva #(
	.DATA_W(DATA_W), .A_RESET_VAL(A_RESET_VAL), .B_RESET_VAL(B_RESET_VAL)
) i_mem_out_sva (
	.sys_clk(sys_clk), .rst(rst), .a_en(a_en), .a_regce(a_regce), .a_rst(a_rst),
	.a_we(a_we), .a_dout(a_dout), .a_dout_valid(a_dout_valid), .b_en(b_en),
	.b_regce(b_regce), .b_rst(b_rst), .b_dout(b_dout)
);
`default_nettype wire

//--- tb/user_port.sv
// User-logic model that launches port strobes at the clock edge
`timescale 1ns/10ps
`default_nettype none
module user_port
	import mem_out_pkg::*;
#(
	parameter logic [9:0]	AD	= 10'h000,
	parameter logic [15:0]	WD	= 16'h0000
) (
	input  wire logic		sys_clk,
	input  wire port_ctrl_type	cmd,
	output var  port_ctrl_type	ctl,
	output var  logic [9:0]		addr,
	output var  logic [15:0]	wdata
);
	// Idle lines toggle so a stale value never passes for a live one
	always @(posedge sys_clk) begin
		ctl <= cmd;
		addr <= cmd.en ? AD : ~addr;
		wdata <= cmd.we ? WD : ~wdata;
	end
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the memory output stage
`timescale 1ns/10ps
`default_nettype none
module testbench
	import mem_out_pkg::*;
;
	logic		sys_clk	= 1'b0;
	logic		rst	= 1'b1;
	port_ctrl_type	ca	= '0;
	port_ctrl_type	cb	= '0;
	port_ctrl_type	pa;
	port_ctrl_type	pb;
	logic [9:0]	a_addr;
	logic [9:0]	b_addr;
	logic [15:0]	a_wdata;
	logic [15:0]	b_wdata;
	logic [15:0]	a_dout;
	logic [15:0]	b_dout;
	logic		a_dout_valid;
	logic		b_dout_valid;
	int		errors	= 0;
	int		n_compared	= 0;
	int		cycles	= 0;
	always #50 sys_clk = ~sys_clk;
	user_port #(.AD(10'h005), .WD(16'h1234)) i_user_a (
		.sys_clk(sys_clk), .cmd(ca), .ctl(pa), .addr(a_addr), .wdata(a_wdata));
	user_port #(.AD(10'h006), .WD(16'habcd)) i_user_b (
		.sys_clk(sys_clk), .cmd(cb), .ctl(pb), .addr(b_addr), .wdata(b_wdata));
	memory_output_stage_reset_control #(
		.A_PRIO(reset_first_priority), .B_LATCH_RST(1'b1)
	) i_memory_output_stage_reset_control (
		.sys_clk(sys_clk), .rst(rst),
		.a_en(pa.en), .a_regce(pa.regce), .a_rst(pa.srst), .a_we(pa.we),
		.a_addr(a_addr), .a_wdata(a_wdata), .a_dout(a_dout), .a_dout_valid(a_dout_valid),
		.b_en(pb.en), .b_regce(pb.regce), .b_rst(pb.srst), .b_we(pb.we),
		.b_addr(b_addr), .b_wdata(b_wdata), .b_dout(b_dout), .b_dout_valid(b_dout_valid));
	task automatic report_and_stop;
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Command rows are {en, regce, srst, we}; outputs show the previous row
	task automatic st(input logic [3:0] a, input logic [3:0] b);
		ca = port_ctrl_type'(a);
		cb = port_ctrl_type'(b);
		@(posedge sys_clk);
		#1;
	endtask
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 200) begin
			errors++;
			report_and_stop();
		end
	end
	initial begin
		repeat (3) @(posedge sys_clk);
		rst <= 1'b0;
		#1;
		st(4'h9, 4'h9);
		st(4'hc, 4'hc);
		st(4'h4, 4'h4);
		cmp({15'h0000, a_dout_valid}, 16'h0000);
		st(4'h4, 4'h4);
		cmp(a_dout, 16'h1234);
		cmp({15'h0000, a_dout_valid}, 16'h0001);
		cmp(b_dout, 16'habcd);
		st(4'ha, 4'h0);
		st(4'h4, 4'h0);
		cmp(a_dout, 16'hffff);
		st(4'h0, 4'h0);
		cmp(a_dout, 16'h1234);
		st(4'h0, 4'h2);
		st(4'h0, 4'h0);
		cmp(b_dout, 16'habcd);
		st(4'h0, 4'he);
		st(4'h0, 4'h4);
		cmp(b_dout, 16'hffff);
		cmp({15'h0000, b_dout_valid}, 16'h0000);
		st(4'h0, 4'h4);
		cmp(b_dout, 16'hffff);
		st(4'h0, 4'hc);
		cmp(b_dout, 16'hffff);
		st(4'h0, 4'h4);
		st(4'h0, 4'h4);
		cmp(b_dout, 16'habcd);
		cmp({15'h0000, b_dout_valid}, 16'h0001);
		st(4'h0, 4'ha);
		st(4'h0, 4'h4);
		cmp(b_dout, 16'habcd);
		st(4'h0, 4'h0);
		cmp(b_dout, 16'hffff);
		report_and_stop();
	end
endmodule
`default_nettype wire
